// ==== mjt_host.sv ====
/*
  Model of the outside boundary-scan controller for the memory test port.
  Assumes core_clk is the bench clock; the test clock runs only inside step.
*/
`timescale 1ns/100ps
`default_nettype none

module mjt_host (
  // Bench clock
  input wire logic core_clk,
  // Test pins driven
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  // Test pins watched
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // Serial output as seen before each rise
  output logic seen_vld,
  output logic seen_tdo,
  output logic seen_oe_n
);
  // ==========================================================
  // Resting levels
  // reset held low, pins at rest
  initial begin
    tck = mjt_pkg::TCK_REST;
    tms = mjt_pkg::TMS_REST;
    tdi = mjt_pkg::TDI_REST;
    trst_n = 1'h0;
    seen_vld = 1'h0;
    seen_tdo = 1'h1;
    seen_oe_n = 1'h1;
  end

  task automatic set_rst(input logic v);
    @(posedge core_clk);
    #1;
    trst_n = v;
    tms = mjt_pkg::TMS_REST;
    tdi = mjt_pkg::TDI_REST;
  endtask

  // ==========================================================
  // One test clock period, 5 cycles low and 3 high
  // inputs settled long before the rise
  task automatic step(input logic tms_v, input logic tdi_v);
    @(posedge core_clk);
    #1;
    tms = tms_v;
    tdi = tdi_v;
    repeat (4) @(posedge core_clk);
    #1;
    seen_tdo = tdo;
    seen_oe_n = tdo_oe_n;
    seen_vld = 1'h1;
    tck = 1'h1;
    @(posedge core_clk);
    #1;
    seen_vld = 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    tck = 1'h0;
  endtask
endmodule // mjt_host

`default_nettype wire

// ==== mjt_pkg.sv ====
/*
  Shared constants and types for the memory test access port.
  Assumes the user writes every reference as mjt_pkg::name.
*/
package mjt_pkg;

  // ==========================================================
  // Register sizes
  localparam int IR_W = 8;
  localparam int ID_W = 32;
  localparam int BSR_W = 113;

  // ==========================================================
  // Instruction codes (restricted set)
  localparam logic [IR_W-1:0] INS_IDCODE = 8'h02;
  localparam logic [IR_W-1:0] INS_SAMPLE = 8'h05;
  localparam logic [IR_W-1:0] INS_BYPASS = 8'hff;
  // Fixed pattern loaded into the instruction shifter in capture-IR
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

  // Identification code; value is arbitrary, bit 0 is the fixed one
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h1000_0001;

  // ==========================================================
  // Resting pin levels in functional mode
  localparam logic TCK_REST = 1'h0;
  localparam logic TMS_REST = 1'h1;
  localparam logic TDI_REST = 1'h1;
  localparam logic TDO_REST = 1'h1;

  // ==========================================================
  // Controller states and data register choice
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } mjt_state_t;

  typedef enum logic [1:0] {
    DR_BYPASS, DR_IDCODE, DR_BOUNDARY
  } mjt_dr_t;

endpackage

// ==== mjt_shift_reg.sv ====
/*
  Capture-and-shift register of parameter width.
  Assumes capture and shift are one-cycle enables on core_clk, never both at once.
*/
`timescale 1ns/100ps
`default_nettype none

module mjt_shift_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic capture_en,
  input wire logic shift_en,
  // Data
  input wire logic [WIDTH-1:0] cap_data,
  input wire logic ser_in,
  output logic [WIDTH-1:0] q
);

  // ==========================================================
  // Register: capture parallel, shift toward bit 0
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (capture_en) begin
      q <= cap_data;
    end else if (shift_en) begin
      q <= {ser_in, q[WIDTH-1:1]};
    end
  end

endmodule // mjt_shift_reg

`default_nettype wire

// ==== mjt_tap.sv ====
/*
  Test access port of the memory device: controller, instruction,
  bypass, identification and boundary registers.
  Assumes the test pins arrive asynchronously and the test clock is
  far slower than core_clk, so its edges are found by sampling.
*/
// Function
// - Only IDCODE, SAMPLE and BYPASS; no full instruction set.
// - Test inputs are taken on the rising edge of the test clock.
// - Test outputs, including serial out, change only on the falling edge or on reset.
// - Sampled mode select alone advances the controller.
// - One serial register sits between in and out, by state and instruction.
// - Test reset low resets the controller asynchronously, clock or not.
// - At rest serial in and mode select high, clock and reset low.
// - Eight-bit instruction register preloads IDCODE in test-logic-reset.
// - One-bit bypass register, cleared to zero when bypass runs.
// - Identification code captured in capture-DR, shifted in shift-DR.
// - 113-bit boundary register captures pins, shifts in shift-DR.
`timescale 1ns/100ps
`default_nettype none

module mjt_tap #(
  parameter logic [mjt_pkg::ID_W-1:0] ID_CODE = mjt_pkg::ID_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe_n,
  // Device pin states seen by the boundary register
  input wire logic [mjt_pkg::BSR_W-1:0] ring_pins,
  // Status
  output logic [mjt_pkg::IR_W-1:0] cur_instr
);

  // ==========================================================
  // Reset: test reset asserts at once, releases synchronously
  logic trst_m;
  logic trst_s;
  logic tap_rst_n;

  always_ff @(posedge core_clk or negedge trst_n or negedge rst_n) begin
    if (!trst_n || !rst_n) begin
      trst_m <= 1'h0;
      trst_s <= 1'h0;
    end else begin
      trst_m <= 1'h1;
      trst_s <= trst_m;
    end
  end

  assign tap_rst_n = trst_s;

  // ==========================================================
  // Pin synchronisers and test clock edges
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  logic tck_d;
  logic [mjt_pkg::BSR_W-1:0] ring_m;
  logic [mjt_pkg::BSR_W-1:0] ring_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= {mjt_pkg::TCK_REST, mjt_pkg::TMS_REST, mjt_pkg::TDI_REST};
      pin_s <= {mjt_pkg::TCK_REST, mjt_pkg::TMS_REST, mjt_pkg::TDI_REST};
      tck_d <= mjt_pkg::TCK_REST;
      ring_m <= '0;
      ring_s <= '0;
    end else begin
      pin_m <= {tck, tms, tdi};
      pin_s <= pin_m;
      tck_d <= pin_s[2];
      ring_m <= ring_pins;
      ring_s <= ring_m;
    end
  end

  wire tck_s = pin_s[2];
  wire tms_s = pin_s[1];
  wire tdi_s = pin_s[0];
  wire tck_rise = tck_s && !tck_d;
  wire tck_fall = !tck_s && tck_d;

  // ==========================================================
  // Controller
  mjt_pkg::mjt_state_t state;
  mjt_pkg::mjt_state_t next_state;

  function automatic mjt_pkg::mjt_state_t tap_next(input mjt_pkg::mjt_state_t s, input logic m);
    case (s)
      mjt_pkg::ST_TLR: tap_next = m ? mjt_pkg::ST_TLR : mjt_pkg::ST_RTI;
      mjt_pkg::ST_RTI: tap_next = m ? mjt_pkg::ST_SEL_DR : mjt_pkg::ST_RTI;
      mjt_pkg::ST_SEL_DR: tap_next = m ? mjt_pkg::ST_SEL_IR : mjt_pkg::ST_CAP_DR;
      mjt_pkg::ST_CAP_DR: tap_next = m ? mjt_pkg::ST_EXIT1_DR : mjt_pkg::ST_SHIFT_DR;
      mjt_pkg::ST_SHIFT_DR: tap_next = m ? mjt_pkg::ST_EXIT1_DR : mjt_pkg::ST_SHIFT_DR;
      mjt_pkg::ST_EXIT1_DR: tap_next = m ? mjt_pkg::ST_UPD_DR : mjt_pkg::ST_PAUSE_DR;
      mjt_pkg::ST_PAUSE_DR: tap_next = m ? mjt_pkg::ST_EXIT2_DR : mjt_pkg::ST_PAUSE_DR;
      mjt_pkg::ST_EXIT2_DR: tap_next = m ? mjt_pkg::ST_UPD_DR : mjt_pkg::ST_SHIFT_DR;
      mjt_pkg::ST_UPD_DR: tap_next = m ? mjt_pkg::ST_SEL_DR : mjt_pkg::ST_RTI;
      mjt_pkg::ST_SEL_IR: tap_next = m ? mjt_pkg::ST_TLR : mjt_pkg::ST_CAP_IR;
      mjt_pkg::ST_CAP_IR: tap_next = m ? mjt_pkg::ST_EXIT1_IR : mjt_pkg::ST_SHIFT_IR;
      mjt_pkg::ST_SHIFT_IR: tap_next = m ? mjt_pkg::ST_EXIT1_IR : mjt_pkg::ST_SHIFT_IR;
      mjt_pkg::ST_EXIT1_IR: tap_next = m ? mjt_pkg::ST_UPD_IR : mjt_pkg::ST_PAUSE_IR;
      mjt_pkg::ST_PAUSE_IR: tap_next = m ? mjt_pkg::ST_EXIT2_IR : mjt_pkg::ST_PAUSE_IR;
      mjt_pkg::ST_EXIT2_IR: tap_next = m ? mjt_pkg::ST_UPD_IR : mjt_pkg::ST_SHIFT_IR;
      mjt_pkg::ST_UPD_IR: tap_next = m ? mjt_pkg::ST_SEL_DR : mjt_pkg::ST_RTI;
      default: tap_next = mjt_pkg::ST_TLR;
    endcase
  endfunction

  // mode select is the only command
  assign next_state = tap_next(state, tms_s);

  always_ff @(posedge core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state <= mjt_pkg::ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Instruction register and decode
  logic [mjt_pkg::IR_W-1:0] ir_q;
  mjt_pkg::mjt_dr_t dr_sel;

  // unknown codes fall back to bypass
  function automatic mjt_pkg::mjt_dr_t dr_of(input logic [mjt_pkg::IR_W-1:0] ins);
    case (ins)
      mjt_pkg::INS_IDCODE: dr_of = mjt_pkg::DR_IDCODE;
      mjt_pkg::INS_SAMPLE: dr_of = mjt_pkg::DR_BOUNDARY;
      default: dr_of = mjt_pkg::DR_BYPASS;
    endcase
  endfunction

  assign dr_sel = dr_of(cur_instr);

  wire in_tlr = (state == mjt_pkg::ST_TLR);
  wire ir_cap = tck_rise && (state == mjt_pkg::ST_CAP_IR);
  wire ir_shift = tck_rise && (state == mjt_pkg::ST_SHIFT_IR);
  wire dr_cap = tck_rise && (state == mjt_pkg::ST_CAP_DR);
  wire dr_shift = tck_rise && (state == mjt_pkg::ST_SHIFT_DR);
  wire id_cap = dr_cap && (dr_sel == mjt_pkg::DR_IDCODE);
  wire id_shift = dr_shift && (dr_sel == mjt_pkg::DR_IDCODE);
  wire bsr_cap = dr_cap && (dr_sel == mjt_pkg::DR_BOUNDARY);
  wire bsr_shift = dr_shift && (dr_sel == mjt_pkg::DR_BOUNDARY);

  mjt_shift_reg #(.WIDTH(mjt_pkg::IR_W)) u_ir_sr (
    .core_clk(core_clk),
    .rst_n(tap_rst_n),
    .capture_en(ir_cap),
    .shift_en(ir_shift),
    .cap_data(mjt_pkg::IR_CAPTURE),
    .ser_in(tdi_s),
    .q(ir_q)
  );

  always_ff @(posedge core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      cur_instr <= mjt_pkg::INS_IDCODE;
    end else if (in_tlr) begin
      cur_instr <= mjt_pkg::INS_IDCODE;
    end else if (tck_rise && state == mjt_pkg::ST_UPD_IR) begin
      cur_instr <= ir_q;
    end
  end

  // ==========================================================
  // Data registers
  logic bypass_q;
  logic [mjt_pkg::ID_W-1:0] id_q;
  logic [mjt_pkg::BSR_W-1:0] bsr_q;

  // bypass cleared on capture, one stage when shifting
  always_ff @(posedge core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_q <= 1'h0;
    end else if (dr_cap && dr_sel == mjt_pkg::DR_BYPASS) begin
      bypass_q <= 1'h0;
    end else if (dr_shift && dr_sel == mjt_pkg::DR_BYPASS) begin
      bypass_q <= tdi_s;
    end
  end

  mjt_shift_reg #(.WIDTH(mjt_pkg::ID_W)) u_id_sr (
    .core_clk(core_clk),
    .rst_n(tap_rst_n),
    .capture_en(id_cap),
    .shift_en(id_shift),
    .cap_data(ID_CODE),
    .ser_in(tdi_s),
    .q(id_q)
  );

  mjt_shift_reg #(.WIDTH(mjt_pkg::BSR_W)) u_bsr_sr (
    .core_clk(core_clk),
    .rst_n(tap_rst_n),
    .capture_en(bsr_cap),
    .shift_en(bsr_shift),
    .cap_data(ring_s),
    .ser_in(tdi_s),
    .q(bsr_q)
  );

  // ==========================================================
  // Serial output
  // one register chosen by state and instruction
  wire dr_bit = (dr_sel == mjt_pkg::DR_IDCODE) ? id_q[0] :
                (dr_sel == mjt_pkg::DR_BOUNDARY) ? bsr_q[0] : bypass_q;
  wire in_shift_ir = (state == mjt_pkg::ST_SHIFT_IR);
  wire in_shift_dr = (state == mjt_pkg::ST_SHIFT_DR);
  wire next_tdo = in_shift_ir ? ir_q[0] : (in_shift_dr ? dr_bit : mjt_pkg::TDO_REST);

  // outputs move on the falling edge
  always_ff @(posedge core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo <= mjt_pkg::TDO_REST;
      tdo_oe_n <= 1'h1;
    end else if (tck_fall) begin
      tdo <= next_tdo;
      tdo_oe_n <= !(in_shift_ir || in_shift_dr);
    end
  end

  // ==========================================================
  // Checks
  sequence s_tlr_exit;
    tck_rise && in_tlr && !tms_s;
  endsequence

  property p_async_reset;
    @(posedge core_clk) disable iff (!rst_n) !trst_n |=> (state == mjt_pkg::ST_TLR);
  endproperty
  a_async_reset: assert property (p_async_reset) else $error("controller not reset by test reset");
  property p_hold_no_rise;
    @(posedge core_clk) disable iff (!tap_rst_n) !tck_rise |=> $stable(state);
  endproperty
  a_hold_no_rise: assert property (p_hold_no_rise) else $error("state moved without a rising edge");
  property p_tlr_to_rti;
    @(posedge core_clk) disable iff (!tap_rst_n) s_tlr_exit |=> (state == mjt_pkg::ST_RTI);
  endproperty
  a_tlr_to_rti: assert property (p_tlr_to_rti) else $error("bad exit from test-logic-reset");
  property p_tdo_on_fall;
    @(posedge core_clk) disable iff (!tap_rst_n) !$stable(tdo) |-> $past(tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("serial out changed off a falling edge");
  property p_ir_preload;
    @(posedge core_clk) disable iff (!tap_rst_n) in_tlr |=> (cur_instr == mjt_pkg::INS_IDCODE);
  endproperty
  a_ir_preload: assert property (p_ir_preload) else $error("instruction not preloaded");
  property p_bypass_clear;
    @(posedge core_clk) disable iff (!tap_rst_n)
      (dr_cap && dr_sel == mjt_pkg::DR_BYPASS) |=> !bypass_q;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear) else $error("bypass not cleared on capture");
  property p_id_capture;
    @(posedge core_clk) disable iff (!tap_rst_n) id_cap |=> (id_q == ID_CODE);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identification code not captured");
  property p_bsr_capture;
    @(posedge core_clk) disable iff (!tap_rst_n) bsr_cap |=> (bsr_q == $past(ring_s));
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("boundary not captured");
  property p_tdo_select;
    @(posedge core_clk) disable iff (!tap_rst_n)
      (tck_fall && in_shift_ir) |=> (tdo == $past(ir_q[0]) && !tdo_oe_n);
  endproperty
  a_tdo_select: assert property (p_tdo_select) else $error("wrong register on serial out");
  property p_tdi_sampled;
    @(posedge core_clk) disable iff (!tap_rst_n)
      (dr_shift && dr_sel == mjt_pkg::DR_BYPASS) |=> (bypass_q == $past(tdi_s));
  endproperty
  a_tdi_sampled: assert property (p_tdi_sampled) else $error("serial in not taken on rising edge");
  property p_idle_out;
    @(posedge core_clk) disable iff (!tap_rst_n)
      (tck_fall && !in_shift_ir && !in_shift_dr) |=> (tdo && tdo_oe_n);
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("serial out not at rest");

endmodule // mjt_tap

`default_nettype wire

// ==== tb.sv ====
/*
  Self-checking bench of the memory test port.
  Assumes mjt_host drives the test pins and notes tdo before each rise.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam logic [31:0] ID_TB = 32'h5a3c_9e17; // Value is arbitrary
  localparam logic H = 1'h1;
  localparam logic L = 1'h0;
  logic core_clk, rst_n;
  logic [112:0] ring_pins;
  wire logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, seen_vld, seen_tdo, seen_oe_n;
  wire logic [7:0] cur_instr;
  logic [1:0] exp_q[$];
  int miscompares, tests_run;

  always #25 core_clk = ~core_clk;

  mjt_tap #(.ID_CODE(ID_TB)) dut (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ring_pins(ring_pins), .cur_instr(cur_instr));
  mjt_host h (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .seen_vld(seen_vld), .seen_tdo(seen_tdo), .seen_oe_n(seen_oe_n));

  // ==========================================================
  // Comparison and closing
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // Output watcher takes the oldest note
  always @(posedge core_clk) begin
    if (seen_vld === 1'h1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("wrong value tdo note expected present seen none");
      end else begin
        check("tdo and enable", 128'({seen_tdo, seen_oe_n}), 128'(exp_q.pop_front()));
      end
    end
  end

  // ==========================================================
  // Controller sequences
  task automatic st(input logic t, input logic d, input logic e_tdo, input logic e_oe);
    exp_q.push_back({e_tdo, e_oe});
    h.step(t, d);
  endtask

  task automatic load_ir(input logic [7:0] code);
    st(H, H, H, H);
    st(H, H, H, H);
    st(L, H, H, H);
    st(L, H, H, H);
    for (int i = 0; i < 8; i++) begin
      st(i == 7, code[i], mjt_pkg::IR_CAPTURE[i], L);
    end
    st(H, H, H, H);
    st(L, H, H, H);
    check("cur_instr", 128'(cur_instr), 128'(code));
  endtask

  task automatic shift_dr(input int n, input logic [127:0] din, input logic [127:0] expv);
    st(H, H, H, H);
    st(L, H, H, H);
    st(L, H, H, H);
    for (int i = 0; i < n; i++) begin
      st(i == n - 1, din[i], expv[i], L);
    end
    st(H, H, H, H);
    st(L, H, H, H);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    $display("wrong value run length expected finish seen timeout");
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [127:0] din;
    logic [7:0] code;
    core_clk = 1'h0;
    rst_n = 1'h0;
    ring_pins = '0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(42864));
    repeat (16) @(posedge core_clk);
    #1;
    check("reset instr", 128'(cur_instr), 128'(mjt_pkg::INS_IDCODE));
    check("reset tdo", 128'({tdo, tdo_oe_n}), 128'({mjt_pkg::TDO_REST, H}));
    rst_n = 1'h1;
    h.set_rst(H);
    repeat (8) @(posedge core_clk);
    st(L, H, H, H);
    shift_dr(32, 128'(ID_TB), 128'(ID_TB));
    load_ir(mjt_pkg::INS_BYPASS);
    din = {$urandom, $urandom, $urandom, $urandom};
    shift_dr(20, din, {din[126:0], L});
    code = 8'($urandom);
    if (code == mjt_pkg::INS_IDCODE || code == mjt_pkg::INS_SAMPLE || code == mjt_pkg::INS_BYPASS) begin
      code = 8'h3c;
    end
    load_ir(code);
    shift_dr(9, din, {din[126:0], L});
    load_ir(mjt_pkg::INS_SAMPLE);
    din = {$urandom, $urandom, $urandom, $urandom};
    ring_pins = din[112:0];
    shift_dr(113, ~din, 128'(din[112:0]));
    // Test reset in mid-shift with the test clock standing
    load_ir(mjt_pkg::INS_BYPASS);
    st(H, H, H, H);
    st(L, H, H, H);
    st(L, H, H, H);
    st(L, H, L, L);
    st(L, L, H, L);
    h.set_rst(L);
    repeat (4) @(posedge core_clk);
    #1;
    check("async reset", 128'({tdo_oe_n, cur_instr}), 128'({H, mjt_pkg::INS_IDCODE}));
    h.set_rst(H);
    repeat (8) @(posedge core_clk);
    st(L, H, H, H);
    load_ir(mjt_pkg::INS_BYPASS);
    for (int i = 0; i < 5; i++) begin
      st(H, H, H, H);
    end
    check("five ones", 128'(cur_instr), 128'(mjt_pkg::INS_IDCODE));
    st(L, H, H, H);
    shift_dr(6, din, 128'(ID_TB));
    // Pause a data shift and an instruction shift midway
    st(H, H, H, H);
    st(L, H, H, H);
    st(L, H, H, H);
    st(H, H, ID_TB[0], L);
    st(L, H, H, H);
    st(H, H, H, H);
    st(L, H, H, H);
    st(H, H, ID_TB[1], L);
    st(H, H, H, H);
    st(H, H, H, H);
    st(H, H, H, H);
    st(L, H, H, H);
    st(L, H, H, H);
    st(H, H, mjt_pkg::IR_CAPTURE[0], L);
    st(L, H, H, H);
    st(H, H, H, H);
    st(L, H, H, H);
    for (int i = 1; i < 8; i++) begin
      st(i == 7, H, mjt_pkg::IR_CAPTURE[i], L);
    end
    st(H, H, H, H);
    st(L, H, H, H);
    check("paused shifts", 128'(cur_instr), 128'(mjt_pkg::INS_BYPASS));
    h.set_rst(L);
    for (int i = 0; i < 100 && exp_q.size() != 0; i++) begin
      @(posedge core_clk);
    end
    check("notes left", 128'(exp_q.size()), 128'(0));
    end_sim();
  end
endmodule // tb

`default_nettype wire
